// *** rtl/i2c_register_read_slave.sv ***
`timescale 1ns/1ns
`default_nettype none
module i2c_register_read_slave
    import i2c_rd_pkg::*;
#(
    parameter int NUM_PORTS = 6,
    // Arbitrary neutral value for the identifier contents
    parameter logic [31:0] SUBSYS_ID = 32'h1a2b_0c3d
) (
    input wire logic mclk, // System clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic [STRAP_W-1:0] addr_strap, // Address strap pins
    input wire logic scl, // Bus clock from the master
    input wire logic sda_in, // Bus data level
    output logic sda_out, // Bus data drive value, always low
    output logic sda_oe, // High while pulling data low
    output logic reg_rd_req, // Register fetch request level
    output logic [PSEL_W-1:0] reg_port, // Port of the fetch
    output logic [RADDR_W-1:0] reg_addr, // Dword address of fetch
    output logic [3:0] reg_be, // Byte enables of the fetch
    input wire logic [31:0] reg_rd_data, // Fetched register word
    input wire logic reg_rd_ack, // Fetch answer strobe
    output logic fetch_busy // Fetch in progress
);

    initial begin
        if (NUM_PORTS < 1 || NUM_PORTS > 31) begin
            $error("NUM_PORTS must lie between 1 and 31");
        end
    end

    // Zero the bytes whose enable is clear
    function automatic logic [31:0] apply_be(input logic [31:0] word,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = word;
        for (int i = 0; i < 4; i++) begin
            if (!be[i]) begin
                res[i*8 +: 8] = 8'h00;
            end
        end
        return res;
    endfunction : apply_be

    //------------------------------------------------------------
    // System clock domain
    //------------------------------------------------------------
    logic [STRAP_W-1:0] strap_s;
    logic strap_taken_q;
    logic [6:0] dev_addr_q;
    logic cmd_tgl_s;
    logic cmd_seen_q;
    logic cmd_new;
    fetch_state_type fetch_state_q;
    logic [FETCH_TIMER_W-1:0] timer_q;
    logic [31:0] buf_q;
    logic buf_tgl_q;
    logic load_now;
    logic [31:0] load_val;
    logic sda_out_q;
    logic req_q;
    logic [PSEL_W-1:0] port_q;
    logic [RADDR_W-1:0] addr_q;
    logic [3:0] be_q;
    logic [2:0] opcode;
    logic [PSEL_W-1:0] psel;
    logic [3:0] be_cmd;
    logic [RADDR_W-1:0] raddr;
    logic port_ok;

    // Link domain state, visible here for quasi-static reads
    logic [7:0] cmd_byte_q [CMD_BYTES] = '{default: 8'h00};
    logic cmd_tgl_q = 1'h0;

    bit_sync #(.WIDTH(STRAP_W), .INIT(1'h0)) strap_sync (
        .clk(mclk),
        .din(addr_strap),
        .dout(strap_s)
    );

    bit_sync #(.WIDTH(1), .INIT(1'h0)) cmd_sync (
        .clk(mclk),
        .din(cmd_tgl_q),
        .dout(cmd_tgl_s)
    );

    // Strap caught once after reset release
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            strap_taken_q <= 1'h0;
            dev_addr_q <= TARGET_ADDR_BASE;
        end else if (!strap_taken_q) begin
            strap_taken_q <= 1'h1;
            dev_addr_q <= TARGET_ADDR_BASE | {4'h0, strap_s}; // R8
        end
    end

    // Command fields, stable while the toggle is fresh
    assign opcode = cmd_byte_q[0][OPC_MSB:OPC_LSB]; // R3
    assign psel = {cmd_byte_q[1][PSEL_HI_MSB:PSEL_HI_LSB],
                   cmd_byte_q[2][PSEL_LO_BIT]}; // R11
    assign be_cmd = cmd_byte_q[2][BE_MSB:BE_LSB]; // R4
    assign raddr = {cmd_byte_q[2][ADDR_HI_MSB:ADDR_HI_LSB],
                    cmd_byte_q[3]}; // R5 R6
    assign port_ok = ({1'h0, psel} < 6'(NUM_PORTS));
    assign cmd_new = cmd_tgl_s ^ cmd_seen_q;

    // Fetch sequencer and external request
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            fetch_state_q <= FETCH_IDLE;
            cmd_seen_q <= cmd_tgl_s; // No stale command after reset
            req_q <= 1'h0;
            port_q <= '0;
            addr_q <= '0;
            be_q <= 4'h0;
            timer_q <= '0;
        end else begin
            case (fetch_state_q)
                FETCH_IDLE: begin
                    if (cmd_new) begin
                        cmd_seen_q <= cmd_tgl_s;
                        if (opcode == OPC_READ_REG) begin // R3
                            port_q <= psel;
                            addr_q <= raddr;
                            be_q <= be_cmd;
                            if (port_ok && raddr != SUBSYS_INDEX) begin
                                req_q <= 1'h1; // R14
                                timer_q <= '0;
                                fetch_state_q <= FETCH_WAIT;
                            end
                        end
                    end
                end
                FETCH_WAIT: begin
                    if (reg_rd_ack || timer_q == FETCH_TIMER_LAST) begin
                        req_q <= 1'h0;
                        fetch_state_q <= FETCH_IDLE;
                    end else begin
                        timer_q <= timer_q + 1'h1;
                    end
                end
                default: begin
                    req_q <= 1'h0;
                    fetch_state_q <= FETCH_IDLE;
                end
            endcase
        end
    end

    // Chooses what lands in the buffer and when
    always_comb begin
        load_now = 1'h0;
        load_val = READ_ZERO;
        if (fetch_state_q == FETCH_IDLE && cmd_new &&
            opcode == OPC_READ_REG) begin
            if (!port_ok) begin
                load_now = 1'h1;
            end else if (raddr == SUBSYS_INDEX) begin
                load_now = 1'h1;
                load_val = apply_be(SUBSYS_ID, be_cmd); // R10
            end
        end else if (fetch_state_q == FETCH_WAIT) begin
            if (reg_rd_ack) begin
                load_now = 1'h1;
                load_val = apply_be(reg_rd_data, be_q); // R4
            end else if (timer_q == FETCH_TIMER_LAST) begin
                load_now = 1'h1;
            end
        end
    end

    // Read buffer and its ready toggle toward the link
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            buf_q <= READ_ZERO;
            buf_tgl_q <= 1'h0;
        end else if (load_now) begin
            buf_q <= load_val; // R14
            buf_tgl_q <= ~buf_tgl_q;
        end
    end

    // Open-drain drive value is held low
    always_ff @(posedge mclk) begin
        sda_out_q <= 1'h0;
    end

    assign sda_out = sda_out_q;
    assign reg_rd_req = req_q;
    assign reg_port = port_q;
    assign reg_addr = addr_q;
    assign reg_be = be_q;
    assign fetch_busy = req_q;

    //------------------------------------------------------------
    // Link clock domain
    //------------------------------------------------------------
    start_cond_if cond ();
    logic link_rst_b;
    logic buf_tgl_s;
    logic [6:0] dev_addr_s;
    link_state_type link_state_q = LINK_IDLE;
    logic [3:0] bit_cnt_q = 4'h0;
    logic [7:0] shift_q = 8'h00;
    logic ack_q = 1'h0;
    logic [2:0] cmd_idx_q = 3'h0;
    logic start_seen_q = 1'h0;
    logic buf_seen_q = 1'h0;
    logic [31:0] rd_word_q = 32'h0000_0000;
    logic [4:0] tx_pos_q = 5'h1f;
    logic sda_oe_q = 1'h0;
    logic start_evt;
    logic [7:0] rx_byte;

    start_detect start_det (
        .scl(scl),
        .sda_in(sda_in),
        .cond(cond)
    );

    bit_sync #(.WIDTH(1), .INIT(1'h1)) rst_sync (
        .clk(scl),
        .din(rst_b),
        .dout(link_rst_b)
    );

    bit_sync #(.WIDTH(1), .INIT(1'h0)) buf_sync (
        .clk(scl),
        .din(buf_tgl_q),
        .dout(buf_tgl_s)
    );

    bit_sync #(.WIDTH(7), .INIT(1'h0)) addr_sync (
        .clk(scl),
        .din(dev_addr_q),
        .dout(dev_addr_s)
    );

    assign start_evt = cond.start_tgl ^ start_seen_q;
    assign rx_byte = {shift_q[6:0], sda_in};

    // Take a fresh buffer word once its toggle arrives
    always_ff @(posedge scl) begin
        if (!link_rst_b) begin
            buf_seen_q <= 1'h0;
            rd_word_q <= READ_ZERO;
        end else if (buf_tgl_s != buf_seen_q) begin
            buf_seen_q <= buf_tgl_s;
            rd_word_q <= buf_q; // R14
        end
    end

    // Bit sampling, byte framing and packet state
    always_ff @(posedge scl) begin
        if (!link_rst_b) begin
            start_seen_q <= cond.start_tgl; // No false start after reset
            link_state_q <= LINK_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ack_q <= 1'h0;
            cmd_idx_q <= 3'h0;
            tx_pos_q <= TX_MSB_POS;
            cmd_tgl_q <= 1'h0;
            for (int i = 0; i < CMD_BYTES; i++) begin
                cmd_byte_q[i] <= 8'h00;
            end
        end else begin
            start_seen_q <= cond.start_tgl;
            if (start_evt) begin
                link_state_q <= LINK_ADDR; // R13
                bit_cnt_q <= FIRST_BIT_DONE;
                shift_q <= {7'h00, sda_in};
                ack_q <= 1'h0;
            end else if (link_state_q == LINK_IDLE) begin
                bit_cnt_q <= 4'h0;
            end else if (bit_cnt_q != ACK_SLOT) begin
                shift_q <= rx_byte;
                bit_cnt_q <= bit_cnt_q + 4'h1;
                if (link_state_q == LINK_READ) begin
                    tx_pos_q <= tx_pos_q - 5'h01; // R7 R12
                end
                if (bit_cnt_q == LAST_DATA_BIT) begin
                    case (link_state_q)
                        LINK_ADDR: begin
                            if (rx_byte[7:1] == dev_addr_s) begin
                                ack_q <= 1'h1; // R8 R15
                            end else begin
                                link_state_q <= LINK_SKIP;
                            end
                        end
                        LINK_CMD: begin
                            if (cmd_idx_q != CMD_IDX_FULL) begin
                                cmd_byte_q[cmd_idx_q[1:0]] <= rx_byte;
                                ack_q <= 1'h1; // R15
                                cmd_idx_q <= cmd_idx_q + 3'h1;
                                if (cmd_idx_q == CMD_IDX_LAST) begin
                                    cmd_tgl_q <= ~cmd_tgl_q; // R14
                                end
                            end else begin
                                link_state_q <= LINK_SKIP;
                            end
                        end
                        default: begin
                            ack_q <= 1'h0;
                        end
                    endcase
                end
            end else begin
                bit_cnt_q <= 4'h0;
                ack_q <= 1'h0;
                case (link_state_q)
                    LINK_ADDR: begin
                        if (shift_q[0] == DIR_READ) begin
                            link_state_q <= LINK_READ; // R2
                            tx_pos_q <= TX_MSB_POS; // R7
                        end else if (shift_q[0] == DIR_WRITE) begin
                            link_state_q <= LINK_CMD; // R1
                            cmd_idx_q <= 3'h0;
                        end
                    end
                    LINK_READ: begin
                        if (sda_in) begin
                            link_state_q <= LINK_SKIP; // R15
                        end
                    end
                    default: begin
                        link_state_q <= link_state_q;
                    end
                endcase
            end
        end
    end

    // Data line drive, changed only while the clock is low
    always_ff @(negedge scl) begin
        if (!link_rst_b) begin
            sda_oe_q <= 1'h0;
        end else if (bit_cnt_q == ACK_SLOT) begin
            sda_oe_q <= ack_q && (link_state_q != LINK_READ); // R15
        end else if (link_state_q == LINK_READ) begin
            sda_oe_q <= ~rd_word_q[tx_pos_q]; // R7 R12
        end else begin
            sda_oe_q <= 1'h0;
        end
    end

    assign sda_oe = sda_oe_q;

endmodule : i2c_register_read_slave
`default_nettype wire

// *** inc/i2c_rd_pkg.sv ***
// Functional notes
// R1 - Write-direction address packet carries command bytes
// R2 - Read-direction address packet returns buffered register
// R3 - Command byte 0 opcode 100b means read
// R4 - Command byte 2 bits 5:2 are byte enables
// R5 - Byte 2: address 11:10 low, port bit high
// R6 - Command byte 3 holds register address 9:2
// R7 - Return bytes 3 down to 0, MSB first
// R8 - Target address 68h when straps read 000
// R9 - Master frames packets with START and STOP
// R10 - Subsystem identifier register readable at F8h
// R11 - Five-bit port select from bytes 1 and 2
// R12 - Reads past four bytes repeat from byte 3
// R13 - Repeated START merges both packets alike
// R14 - Command phase fetches register into 32-bit buffer
// R15 - Acknowledge address and accepted command bytes
package i2c_rd_pkg;

    // Bus address and direction
    localparam logic [6:0] TARGET_ADDR_BASE = 7'h68;
    localparam int STRAP_W = 3;
    localparam logic DIR_WRITE = 1'h0;
    localparam logic DIR_READ = 1'h1;

    // Command byte layout
    localparam int CMD_BYTES = 4;
    localparam logic [2:0] CMD_IDX_LAST = 3'h3;
    localparam logic [2:0] CMD_IDX_FULL = 3'h4;
    localparam int OPC_MSB = 2;
    localparam int OPC_LSB = 0;
    localparam logic [2:0] OPC_READ_REG = 3'h4;
    localparam int PSEL_HI_MSB = 3;
    localparam int PSEL_HI_LSB = 0;
    localparam int PSEL_LO_BIT = 7;
    localparam int BE_MSB = 5;
    localparam int BE_LSB = 2;
    localparam int ADDR_HI_MSB = 1;
    localparam int ADDR_HI_LSB = 0;
    localparam int PSEL_W = 5;
    localparam int RADDR_W = 10;

    // Register map and read values
    localparam logic [11:0] SUBSYS_OFFSET = 12'h0f8;
    localparam logic [RADDR_W-1:0] SUBSYS_INDEX = SUBSYS_OFFSET[11:2];
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // Bit framing on the link
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] FIRST_BIT_DONE = 4'h1;
    localparam logic [4:0] TX_MSB_POS = 5'h1f;

    // Fetch timeout
    localparam int CLK_PERIOD_NS = 10;
    localparam int FETCH_TIMEOUT_NS = 2560;
    localparam int FETCH_TIMEOUT_CYC =
        (FETCH_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FETCH_TIMER_W = $clog2(FETCH_TIMEOUT_CYC + 1);
    localparam logic [FETCH_TIMER_W-1:0] FETCH_TIMER_LAST =
        FETCH_TIMER_W'(FETCH_TIMEOUT_CYC - 1);

    typedef enum logic [2:0] {
        LINK_IDLE,
        LINK_ADDR,
        LINK_CMD,
        LINK_READ,
        LINK_SKIP
    } link_state_type;

    typedef enum logic [1:0] {
        FETCH_IDLE,
        FETCH_WAIT
    } fetch_state_type;

endpackage : i2c_rd_pkg

// *** inc/start_cond_if.sv ***
`timescale 1ns/1ns
`default_nettype none
// Start condition event from the data-edge detector
interface start_cond_if;
    logic start_tgl;
    modport detect (output start_tgl);
    modport engine (input start_tgl);
endinterface : start_cond_if
`default_nettype wire

// *** rtl/bit_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module bit_sync #(
    parameter int WIDTH = 1,
    parameter logic INIT = 1'h0
) (
    input wire logic clk, // Destination clock
    input wire logic [WIDTH-1:0] din, // Level from another domain
    output logic [WIDTH-1:0] dout // Level after two flops
);
    logic [WIDTH-1:0] meta_q = {WIDTH{INIT}};
    logic [WIDTH-1:0] dout_q = {WIDTH{INIT}};

    initial begin
        if (WIDTH < 1) begin
            $error("bit_sync WIDTH must be at least 1");
        end
    end

    // Two-stage synchroniser, first stage read only by second
    always_ff @(posedge clk) begin
        meta_q <= din;
        dout_q <= meta_q;
    end

    assign dout = dout_q;
endmodule : bit_sync
`default_nettype wire

// *** rtl/start_detect.sv ***
`timescale 1ns/1ns
`default_nettype none
module start_detect (
    input wire logic scl, // Bus clock level
    input wire logic sda_in, // Bus data level, used as edge
    start_cond_if.detect cond // Start event toggle out
);
    logic start_tgl_q = 1'h0;

    // Data falling while clock is high marks a start
    always_ff @(negedge sda_in) begin
        if (scl) begin
            start_tgl_q <= ~start_tgl_q; // R9 R13
        end
    end

    assign cond.start_tgl = start_tgl_q;
endmodule : start_detect
`default_nettype wire

// *** tb/i2c_register_read_slave_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module i2c_rd_checker
    import i2c_rd_pkg::*;
#(
    parameter int NUM_PORTS = 6
) (
    input wire logic mclk, // System clock
    input wire logic rst_b, // Reset, active low
    input wire logic [STRAP_W-1:0] addr_strap, // Straps
    input wire logic scl, // Bus clock
    input wire logic sda_in, // Bus data
    input wire logic sda_out, // Drive value
    input wire logic sda_oe, // Drive enable
    input wire logic reg_rd_req, // Fetch request
    input wire logic [PSEL_W-1:0] reg_port, // Fetch port
    input wire logic [RADDR_W-1:0] reg_addr, // Fetch address
    input wire logic [3:0] reg_be, // Fetch enables
    input wire logic [31:0] reg_rd_data, // Fetch data
    input wire logic reg_rd_ack, // Fetch answer
    input wire logic fetch_busy // Fetch busy
);
    // Cycles spent waiting on the current fetch
    logic [8:0] wait_q;
    always_ff @(posedge mclk) begin
        if (!rst_b || !reg_rd_req) begin
            wait_q <= 9'h000;
        end else begin
            wait_q <= wait_q + 9'h001;
        end
    end
    // Drive level seen at each rising bus clock
    logic oe_rise_q = 1'h0;
    always_ff @(posedge scl) begin
        oe_rise_q <= sda_oe;
    end
    a_busy_mirror: assert property (
        @(posedge mclk) disable iff (!rst_b) fetch_busy == reg_rd_req)
        else $error("busy flag differs from request");
    a_ack_ends_req: assert property (
        @(posedge mclk) disable iff (!rst_b)
        reg_rd_req && reg_rd_ack |=> !reg_rd_req)
        else $error("request stayed after answer");
    a_req_bounded: assert property (
        @(posedge mclk) disable iff (!rst_b)
        $rose(reg_rd_req) |-> ##[1:300] !reg_rd_req)
        else $error("request never ended");
    a_req_waits: assert property (
        @(posedge mclk) disable iff (!rst_b)
        reg_rd_req && !reg_rd_ack && wait_q < 9'h0c8 |=> reg_rd_req)
        else $error("request dropped without answer");
    a_fetch_steady: assert property (
        @(posedge mclk) disable iff (!rst_b)
        reg_rd_req && $past(reg_rd_req)
        |-> $stable({reg_port, reg_addr, reg_be}))
        else $error("fetch fields moved during request");
    a_port_legal: assert property (
        @(posedge mclk) disable iff (!rst_b)
        reg_rd_req |-> reg_port < PSEL_W'(NUM_PORTS))
        else $error("fetch to missing port");
    a_subsys_local: assert property (
        @(posedge mclk) disable iff (!rst_b)
        reg_rd_req |-> reg_addr != SUBSYS_INDEX)
        else $error("identifier fetched outside");
    a_drive_low: assert property (
        @(posedge mclk) disable iff (!rst_b) sda_out == 1'h0)
        else $error("data driven high");
    a_bit_stands: assert property (
        @(negedge scl) disable iff (!rst_b) sda_oe == oe_rise_q)
        else $error("data drive moved while clock high");
    c_fetch_acked: cover property (
        @(posedge mclk) reg_rd_req && reg_rd_ack);
    c_fetch_timeout: cover property (
        @(posedge mclk) wait_q == 9'h0ff);
    c_bus_driven: cover property (
        @(negedge scl) sda_oe);
endmodule : i2c_rd_checker
bind i2c_register_read_slave i2c_rd_checker #(.NUM_PORTS(NUM_PORTS))
    i2c_rd_checker_inst (.mclk(mclk), .rst_b(rst_b),
    .addr_strap(addr_strap), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .reg_rd_req(reg_rd_req),
    .reg_port(reg_port), .reg_addr(reg_addr), .reg_be(reg_be),
    .reg_rd_data(reg_rd_data), .reg_rd_ack(reg_rd_ack),
    .fetch_busy(fetch_busy));
`default_nettype wire

// *** tb/bus_master.sv ***
`timescale 1ns/1ns
`default_nettype none
module bus_master (
    output logic scl, // Bus clock, 12 ns slots
    output logic m_oe, // High while pulling data low
    input wire logic sda // Resolved data level
);
    // Idle bus, clock stands high
    initial begin
        scl = 1'h1;
        m_oe = 1'h0;
    end
    // One bit slot, data moves only while clock low
    task automatic bit_slot(input logic b, output logic r);
        scl = 1'h0;
        #2 m_oe = ~b;
        #4 scl = 1'h1;
        #1 r = sda;
        #5;
    endtask : bit_slot
    // Stop when stp high, else start or repeated start
    task automatic frame(input logic stp);
        scl = 1'h0;
        #2 m_oe = stp;
        #4 scl = 1'h1;
        #4 m_oe = ~stp;
        #6;
    endtask : frame
    // Byte MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            bit_slot(tx[i], rx[i]);
        end
        bit_slot(ack_in, ack_out);
    endtask : xfer
endmodule : bus_master
`default_nettype wire

// *** tb/i2c_register_read_slave_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module i2c_register_read_slave_bench
    import i2c_rd_pkg::*;
;
    localparam logic [31:0] SID = 32'h5e6f_7a8b; // Arbitrary value
    logic mclk, rst_b, scl, m_oe, sda, sda_out, sda_oe;
    logic reg_rd_req, reg_rd_ack, fetch_busy, quiet;
    logic [7:0] dev_w;
    logic [STRAP_W-1:0] addr_strap;
    logic [PSEL_W-1:0] reg_port;
    logic [RADDR_W-1:0] reg_addr;
    logic [3:0] reg_be;
    logic [31:0] reg_rd_data;
    int err_count, compares, cyc, ack_dly, wcnt;
    assign sda = ~(sda_oe | m_oe);
    i2c_register_read_slave #(.SUBSYS_ID(SID))
        i2c_register_read_slave_inst (.mclk(mclk), .rst_b(rst_b),
        .addr_strap(addr_strap), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .reg_rd_req(reg_rd_req),
        .reg_port(reg_port), .reg_addr(reg_addr), .reg_be(reg_be),
        .reg_rd_data(reg_rd_data), .reg_rd_ack(reg_rd_ack),
        .fetch_busy(fetch_busy));
    bus_master bus_master_inst (.scl(scl), .m_oe(m_oe), .sda(sda));
    // System clock
    initial begin
        mclk = 1'h0;
    end
    always #5 mclk = ~mclk;
    // Register source, answers after ack_dly cycles unless quiet
    always @(negedge mclk) begin
        reg_rd_ack <= 1'h0;
        reg_rd_data <= {reg_port, 1'h0, reg_addr, 16'ha5c3};
        if (reg_rd_req && !reg_rd_ack && !quiet) begin
            wcnt <= wcnt + 1;
            if (wcnt >= ack_dly) begin
                reg_rd_ack <= 1'h1;
                wcnt <= 0;
            end
        end else begin
            wcnt <= 0;
        end
    end
    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    // Counts and verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    // One comparison
    task automatic chk(string w, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    // Source word with disabled bytes cleared
    function automatic logic [31:0] ew(logic [4:0] p, logic [9:0] x,
                                       logic [3:0] be);
        logic [31:0] w;
        w = {p, 1'h0, x, 16'ha5c3};
        for (int k = 0; k < 4; k++) begin
            if (!be[k]) w[8*k +: 8] = 8'h00;
        end
        return w;
    endfunction : ew
    // Bus clock pulses with data released, no frame
    task automatic idle_slots(int k);
        logic r;
        repeat (k) bus_master_inst.bit_slot(1'h1, r);
    endtask : idle_slots
    // Command packet, fetch wait, then read packet
    task automatic rd_test(logic [7:0] op, logic [4:0] p, logic [3:0] be,
                           logic [9:0] x, logic merged, logic xtra,
                           int nb, logic [31:0] exp);
        logic [7:0] rx;
        logic a;
        logic [7:0] cmd [4];
        int n;
        cmd = '{op, {4'h0, p[4:1]}, {p[0], 1'h0, be, x[9:8]}, x[7:0]};
        bus_master_inst.frame(1'h0);
        bus_master_inst.xfer(dev_w, 1'h1, rx, a);
        chk("write address ack", 1'h0, a);
        for (int i = 0; i < 4; i++) begin
            bus_master_inst.xfer(cmd[i], 1'h1, rx, a);
            chk("command ack", 1'h0, a);
        end
        if (xtra) begin
            bus_master_inst.xfer(8'h00, 1'h1, rx, a);
            chk("fifth byte ack", 1'h1, a);
        end
        if (!merged) bus_master_inst.frame(1'h1);
        n = 0;
        repeat (8) @(negedge mclk);
        while (fetch_busy !== 1'h0 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        chk("fetch idle", 1'h0, fetch_busy);
        repeat (8) @(posedge mclk);
        bus_master_inst.frame(1'h0);
        bus_master_inst.xfer(dev_w | 8'h01, 1'h1, rx, a);
        chk("read address ack", 1'h0, a);
        for (int i = 0; i < nb; i++) begin
            bus_master_inst.xfer(8'hff, i == nb - 1, rx, a);
            chk("read byte", exp[8*(3-i%4) +: 8], rx);
        end
        bus_master_inst.frame(1'h1);
        $display("read test done op %h port %h", op, p);
    endtask : rd_test
    // Main sequence
    initial begin
        logic [7:0] rx0;
        logic a0;
        rst_b = 1'h0;
        addr_strap = 3'h0;
        reg_rd_ack = 1'h0;
        reg_rd_data = 32'h0000_0000;
        quiet = 1'h0;
        ack_dly = 0;
        wcnt = 0;
        dev_w = 8'hd0;
        repeat (12) @(negedge mclk);
        rst_b = 1'h1;
        repeat (12) @(negedge mclk);
        idle_slots(2);
        rd_test(8'h04, 5'h0, 4'hf, SUBSYS_INDEX, 1'h0, 1'h0, 8, SID);
        rd_test(8'h04, 5'h6, 4'hf, 10'h001, 1'h0, 1'h0, 4,
                32'h0000_0000);
        ack_dly = 20;
        rd_test(8'h04, 5'h5, 4'h5, 10'h3ff, 1'h1, 1'h0, 5,
                ew(5'h5, 10'h3ff, 4'h5));
        chk("port", 5'h5, reg_port);
        chk("address", 10'h3ff, reg_addr);
        chk("enables", 4'h5, reg_be);
        ack_dly = 0;
        rd_test(8'h04, 5'h1, 4'hf, 10'h001, 1'h0, 1'h0, 4,
                ew(5'h1, 10'h001, 4'hf));
        rd_test(8'h03, 5'h2, 4'hf, 10'h010, 1'h0, 1'h1, 4,
                ew(5'h1, 10'h001, 4'hf));
        quiet = 1'h1;
        rd_test(8'h04, 5'h3, 4'hf, 10'h002, 1'h0, 1'h0, 4,
                32'h0000_0000);
        quiet = 1'h0;
        bus_master_inst.frame(1'h0);
        bus_master_inst.xfer(8'hd2, 1'h1, rx0, a0);
        chk("foreign address ack", 1'h1, a0);
        bus_master_inst.frame(1'h1);
        $display("foreign address test done");
        @(negedge mclk);
        rst_b = 1'h0;
        addr_strap = 3'h5;
        idle_slots(3);
        repeat (12) @(negedge mclk);
        rst_b = 1'h1;
        repeat (12) @(negedge mclk);
        idle_slots(2);
        chk("enables after reset", 4'h0, reg_be);
        dev_w = 8'hda;
        rd_test(8'h04, 5'h0, 4'hc, SUBSYS_INDEX, 1'h1, 1'h0, 4,
                {SID[31:16], 16'h0000});
        bus_master_inst.frame(1'h0);
        bus_master_inst.xfer(8'hd0, 1'h1, rx0, a0);
        chk("old address ack", 1'h1, a0);
        bus_master_inst.frame(1'h1);
        $display("strap address test done");
        summarize();
    end
endmodule : i2c_register_read_slave_bench
`default_nettype wire
